//--- ceer_top.sv
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`include "ceer_cfg.svh"
`default_nettype none
module ceer_top #(
  parameter int STACK_DEPTH = 64
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Event sources
  input  wire logic [3:0]          irq_level,
  output logic      [3:0]          irq_ack,
  input  wire logic                exc_req,
  input  wire logic [3:0]          exc_code,
  output logic                     exc_ack,
  input  wire logic [3:0]          crit_req,
  output logic      [3:0]          crit_ack,
  input  wire logic                dbg_req,
  input  wire logic                dbg_exit,
  // Pipeline side
  input  wire logic                insn_boundary,
  input  wire logic                scall_req,
  input  wire logic                rets_req,
  input  wire logic                rete_req,
  input  wire ceer_pkg::ceer_ctx_t ctx,
  output logic                     core_stall,
  output ceer_pkg::ceer_pcld_t     pc_load,
  output ceer_pkg::ceer_regwr_t    reg_restore,
  output logic [31:0]              status_reg,
  output ceer_pkg::ceer_mode_t     reg_bank,
  output logic                     dbg_mode,
  // Interrupt
  output logic                     irq_out
);
  import ceer_pkg::*;

  localparam int SPW = $clog2(STACK_DEPTH);

  if (STACK_DEPTH < 16 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("STACK_DEPTH must be a power of two of at least 16");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ceer_state_t  state_r;
  logic [31:0]  sr_r;
  logic [31:0]  hbase_r;
  logic [4:0]   evt_sts_r;
  logic [4:0]   evt_msk_r;
  logic [SPW:0] sp_r;
  logic [3:0]   cnt_r;
  logic [3:0]   frame_r;
  ceer_ctx_t    ctx_r;
  logic [31:0]  saved_sr_r;
  logic [31:0]  handler_r;
  logic [5:0]   cause_r;
  logic         dbg_mode_r;
  logic         rd_vld_r;
  logic [3:0]   rd_idx_r;
  ceer_pcld_t   pc_load_r;
  ceer_regwr_t  restore_r;
  logic [31:0]  stk_rdata;

  // ----------------------------------------------------------------
  // Acceptance decode
  // ----------------------------------------------------------------
  wire         idle_w    = (state_r == CEER_S_IDLE);
  wire         take_w    = idle_w & insn_boundary;
  wire         gm_w      = sr_r[`CEER_SR_GM];
  wire [3:0]   irq_ok_w;
  for (genvar k = 0; k < 4; k++) begin : g_lvl
    assign irq_ok_w[k] = irq_level[k] & ~sr_r[`CEER_SR_I0M + k] & ~gm_w;
  end
  wire         crit_w    = take_w & (|crit_req);
  wire         exc_w     = take_w & ~(|crit_req) & exc_req & ~sr_r[`CEER_SR_EM] & ~gm_w;
  wire         irq_w     = take_w & ~(|crit_req) & ~exc_w & (|irq_ok_w);
  wire         event_w   = crit_w | exc_w | irq_w;
  wire         dbg_w     = take_w & ~event_w & dbg_req & ~sr_r[`CEER_SR_DM] & ~dbg_mode_r;
  wire         scall_w   = take_w & ~event_w & ~dbg_w & scall_req;
  wire         rets_w    = take_w & ~event_w & ~dbg_w & ~scall_req & rets_req;
  wire         rete_w    = take_w & ~event_w & ~dbg_w & ~scall_req & ~rets_req & rete_req;
  wire [1:0]   irq_lvl_w = irq_ok_w[3] ? 2'h3 : irq_ok_w[2] ? 2'h2 : irq_ok_w[1] ? 2'h1 : 2'h0;
  wire [1:0]   crit_idx_w = crit_req[0] ? 2'h0 : crit_req[1] ? 2'h1 : crit_req[2] ? 2'h2 : 2'h3;
  wire [3:0]   lvl_mask_w = {irq_lvl_w == 2'h3, irq_lvl_w >= 2'h2, irq_lvl_w >= 2'h1, 1'b1};
  wire [5:0]   cause_w   = crit_w ? `CEER_CAUSE_CRIT + {4'h0, crit_idx_w} :
                           exc_w  ? `CEER_CAUSE_EXC + {2'h0, exc_code} :
                           irq_w  ? {4'h0, irq_lvl_w} : `CEER_CAUSE_SCALL;
  wire         nmi_w     = crit_w & (crit_idx_w == 2'h0);
  wire [2:0]   ent_mode_w = nmi_w ? 3'(CEER_M_NMI) : (crit_w | exc_w) ? 3'(CEER_M_EXC) :
                            irq_w ? 3'(CEER_M_IRQ_LEVEL0) + {1'b0, irq_lvl_w} : 3'(CEER_M_SUP);
  wire         entry_w   = event_w | scall_w;
  wire         ret_w     = rets_w | rete_w;
  ceer_mode_t  cur_mode_w;
  assign cur_mode_w = ceer_mode_t'(sr_r[`CEER_SR_MODE +: 3]);
  wire         in_int_w  = cur_mode_w inside {CEER_M_IRQ_LEVEL0, CEER_M_IRQ_LEVEL1, CEER_M_IRQ_LEVEL2, CEER_M_IRQ_LEVEL3};
  wire [3:0]   ret_frame_w = (rete_w & in_int_w) ? `CEER_FRAME_LONG : `CEER_FRAME_SHORT;

  assign irq_ack  = irq_w ? (4'h1 << irq_lvl_w) : 4'h0;
  assign exc_ack  = exc_w;
  assign crit_ack = crit_w ? (4'h1 << crit_idx_w) : 4'h0;

  logic [31:0] sr_ent;
  always_comb begin
    sr_ent = sr_r;
    sr_ent[`CEER_SR_MODE +: 3] = ent_mode_w;
    if (crit_w | exc_w) begin
      sr_ent[`CEER_SR_EM] = 1'b1;
      sr_ent[`CEER_SR_GM] = 1'b1;
      sr_ent[`CEER_SR_I0M +: 4] = 4'hf;
    end else if (irq_w) begin
      sr_ent[`CEER_SR_I0M +: 4] = sr_r[`CEER_SR_I0M +: 4] | lvl_mask_w;
    end
  end

  // ----------------------------------------------------------------
  // System stack
  // ----------------------------------------------------------------
  wire         push_w    = (state_r == CEER_S_PUSH);
  wire         pop_w     = (state_r == CEER_S_POP);
  wire         full_w    = (sp_r == (SPW + 1)'(STACK_DEPTH));
  wire         empty_w   = (sp_r == '0);
  wire [SPW:0] sp_dec_w  = sp_r - (SPW + 1)'(1);
  wire [2:0]   r_sel_w   = 3'(cnt_r - 4'h2);
  wire [31:0]  push_data_w = (cnt_r == 4'h0) ? saved_sr_r :
                             (cnt_r == 4'h1) ? ctx_r.pc :
                             (cnt_r == 4'h7) ? ctx_r.lr : ctx_r.r8_12[r_sel_w];
  wire         stk_err_w = (push_w & full_w) | (pop_w & empty_w);

  ceer_stack_mem #(
    .DEPTH (STACK_DEPTH),
    .AW    (SPW)
  ) u_stack (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (push_w & ~full_w),
    .waddr   (sp_r[SPW-1:0]),
    .wdata   (push_data_w),
    .re      (pop_w & ~empty_w),
    .raddr   (sp_dec_w[SPW-1:0]),
    .rdata   (stk_rdata)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  ceer_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CEER_S_IDLE:  begin
        if (entry_w) begin
          state_nxt = CEER_S_PUSH;
        end else if (ret_w) begin
          state_nxt = CEER_S_POP;
        end
      end
      CEER_S_PUSH:  state_nxt = (cnt_r == frame_r - 4'h1) ? CEER_S_IDLE : CEER_S_PUSH;
      CEER_S_POP:   state_nxt = (cnt_r == 4'h0) ? CEER_S_DRAIN : CEER_S_POP;
      CEER_S_DRAIN: state_nxt = CEER_S_IDLE;
      default:      state_nxt = CEER_S_IDLE;
    endcase
  end

  assign core_stall = ~idle_w | entry_w | ret_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= CEER_S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 4'h0;
      frame_r <= `CEER_FRAME_SHORT;
      sp_r <= '0;
    end else if (entry_w) begin
      cnt_r <= 4'h0;
      frame_r <= irq_w ? `CEER_FRAME_LONG : `CEER_FRAME_SHORT;
    end else if (ret_w) begin
      cnt_r <= ret_frame_w - 4'h1;
      frame_r <= ret_frame_w;
    end else if (push_w) begin
      cnt_r <= cnt_r + 4'h1;
      sp_r <= full_w ? sp_r : sp_r + (SPW + 1)'(1);
    end else if (pop_w) begin
      cnt_r <= cnt_r - 4'h1;
      sp_r <= empty_w ? sp_r : sp_dec_w;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctx_r <= '0;
      saved_sr_r <= 32'h0;
      handler_r <= 32'h0;
      cause_r <= 6'h0;
    end else if (entry_w) begin
      ctx_r <= ctx;
      saved_sr_r <= sr_r;
      handler_r <= hbase_r + {24'h0, cause_w, 2'h0};
      cause_r <= cause_w;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_vld_r <= 1'b0;
      rd_idx_r <= 4'h0;
    end else begin
      rd_vld_r <= pop_w;
      rd_idx_r <= cnt_r;
    end
  end

  // Restored words other than the status word go back to the program counter or the register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_load_r <= '0;
      restore_r <= '0;
    end else begin
      pc_load_r.vld <= (push_w & (cnt_r == frame_r - 4'h1)) | (rd_vld_r & (rd_idx_r == 4'h1));
      pc_load_r.addr <= push_w ? handler_r : stk_rdata;
      restore_r.vld <= rd_vld_r & (rd_idx_r > 4'h1);
      restore_r.idx <= (rd_idx_r == 4'h7) ? `CEER_REG_LR : `CEER_REG_R8 + rd_idx_r - 4'h2;
      restore_r.data <= stk_rdata;
    end
  end

  assign pc_load     = pc_load_r;
  assign reg_restore = restore_r;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;

  wire        wr_go_w  = aw_held_r & w_held_r & ~bvalid_r;
  wire [31:0] wmask_w  = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire        wr_sr_w  = wr_go_w & (awaddr_r == `CEER_OFS_SR);
  wire        wr_hb_w  = wr_go_w & (awaddr_r == `CEER_OFS_HBASE);
  wire        wr_sts_w = wr_go_w & (awaddr_r == `CEER_OFS_EVT_STS);
  wire        wr_msk_w = wr_go_w & (awaddr_r == `CEER_OFS_EVT_MSK);
  wire        wr_hit_w = wr_sr_w | wr_hb_w | wr_sts_w | wr_msk_w;
  wire        rd_go_w  = s_axi_arvalid & ~rvalid_r;
  wire        rd_hit_w = (s_axi_araddr <= `CEER_OFS_CORE_ST) & (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] rd_mux_w = (s_axi_araddr == `CEER_OFS_SR)      ? sr_r :
                         (s_axi_araddr == `CEER_OFS_HBASE)   ? hbase_r :
                         (s_axi_araddr == `CEER_OFS_EVT_STS) ? {27'h0, evt_sts_r} :
                         (s_axi_araddr == `CEER_OFS_EVT_MSK) ? {27'h0, evt_msk_r} :
                         (s_axi_araddr == `CEER_OFS_STK_LVL) ? 32'(sp_r) :
                         (s_axi_araddr == `CEER_OFS_CORE_ST) ?
                           {17'h0, cause_r, 5'h0, dbg_mode_r, state_r, 1'b0} : 32'h0;

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go_w) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go_w) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else begin
      if (wr_go_w) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit_w ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_go_w) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux_w;
        rresp_r <= rd_hit_w ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, control and interrupt registers
  // ----------------------------------------------------------------
  wire [4:0] ev_set_w = {scall_w, dbg_w, stk_err_w, state_r == CEER_S_DRAIN, push_w & (cnt_r == frame_r - 4'h1)};
  wire [4:0] ev_clr_w = wr_sts_w ? (wdata_r[4:0] & wmask_w[4:0]) : 5'h0;

  // Hardware updates of the status register win over a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_r <= `CEER_SR_RST;
    end else if (entry_w) begin
      sr_r <= sr_ent;
    end else if (rd_vld_r & (rd_idx_r == 4'h0)) begin
      sr_r <= stk_rdata;
    end else if (wr_sr_w) begin
      sr_r <= (sr_r & ~wmask_w) | (wdata_r & wmask_w);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hbase_r <= `CEER_HBASE_RST;
      evt_msk_r <= `CEER_EVT_MSK_RST;
      evt_sts_r <= 5'h0;
      dbg_mode_r <= 1'b0;
    end else begin
      if (wr_hb_w) begin
        hbase_r <= (hbase_r & ~wmask_w) | (wdata_r & wmask_w);
      end
      if (wr_msk_w) begin
        evt_msk_r <= (evt_msk_r & ~wmask_w[4:0]) | (wdata_r[4:0] & wmask_w[4:0]);
      end
      evt_sts_r <= (evt_sts_r & ~ev_clr_w) | ev_set_w;
      dbg_mode_r <= dbg_w | (dbg_mode_r & ~dbg_exit);
    end
  end

  assign status_reg = sr_r;
  assign reg_bank   = cur_mode_w;
  assign dbg_mode   = dbg_mode_r;
  assign irq_out    = |(evt_sts_r & evt_msk_r);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_MASKED_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    |irq_ack |-> !gm_w && !(|(irq_ack & sr_r[`CEER_SR_I0M +: 4])))
    else $error("masked interrupt level acknowledged");
  AST_CRIT_TAKEN: assert property (@(posedge aclk) disable iff (!aresetn)
    idle_w && insn_boundary && (|crit_req) |-> (|crit_ack) ##1 state_r == CEER_S_PUSH)
    else $error("critical event not taken");
  AST_LVL_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_ack[2] |=> sr_r[`CEER_SR_I0M +: 3] == 3'h7)
    else $error("lower level masks not set on entry");
  AST_EXC_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    exc_ack |=> sr_r[`CEER_SR_EM] && sr_r[`CEER_SR_GM] && reg_bank == CEER_M_EXC)
    else $error("exception entry did not set masks and mode");
  AST_SHORT_FRAME: assert property (@(posedge aclk) disable iff (!aresetn)
    exc_ack |=> push_w [*2] ##1 idle_w && pc_load.vld)
    else $error("exception frame not two words");
  AST_LONG_FRAME: assert property (@(posedge aclk) disable iff (!aresetn)
    (|irq_ack) |=> push_w [*8] ##1 idle_w)
    else $error("interrupt frame not eight words");
  AST_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
    !idle_w |-> core_stall && irq_ack == 4'h0 && !exc_ack)
    else $error("event accepted inside a running sequence");
  AST_HANDLER: assert property (@(posedge aclk) disable iff (!aresetn)
    exc_ack ##1 1'b1 [*2] ##1 pc_load.vld |->
      pc_load.addr == hbase_r + {24'h0, `CEER_CAUSE_EXC + {2'h0, $past(exc_code, 3)}, 2'h0})
    else $error("wrong exception handler address");
  AST_RETE_REGS: assert property (@(posedge aclk) disable iff (!aresetn)
    rete_w && in_int_w |-> ##[2:4] reg_restore.vld && reg_restore.idx == `CEER_REG_LR)
    else $error("link register not restored on interrupt return");
  AST_RETS: assert property (@(posedge aclk) disable iff (!aresetn)
    rets_w |-> ##3 pc_load.vld ##1 sr_r == $past(stk_rdata))
    else $error("supervisor return did not restore pc and status");
  AST_DEBUG: assert property (@(posedge aclk) disable iff (!aresetn)
    insn_boundary && idle_w && dbg_req && sr_r[`CEER_SR_DM] |=> $stable(dbg_mode))
    else $error("masked debug request changed debug mode");
  AST_BOUNDARY: assert property (@(posedge aclk) disable iff (!aresetn)
    !insn_boundary |-> irq_ack == 4'h0 && crit_ack == 4'h0 && !exc_ack)
    else $error("event accepted off an instruction boundary");
endmodule : ceer_top
`default_nettype wire

//--- ceer_cfg.svh
`ifndef CEER_CFG_SVH
`define CEER_CFG_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CEER_OFS_SR      8'h00
`define CEER_OFS_HBASE   8'h04
`define CEER_OFS_EVT_STS 8'h08
`define CEER_OFS_EVT_MSK 8'h0c
`define CEER_OFS_STK_LVL 8'h10
`define CEER_OFS_CORE_ST 8'h14
// ----------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------
`define CEER_SR_GM       16
`define CEER_SR_I0M      17
`define CEER_SR_EM       21
`define CEER_SR_MODE     22
`define CEER_SR_DM       26
`define CEER_SR_RST      32'h0041_0000
`define CEER_HBASE_RST   32'h0000_0000
`define CEER_EVT_MSK_RST 5'h00
// ----------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------
`define CEER_EV_ENTRY    0
`define CEER_EV_RETURN   1
`define CEER_EV_STACK    2
`define CEER_EV_DEBUG    3
`define CEER_EV_SCALL    4
// ----------------------------------------------------------------
// Handler cause numbers, frame sizes, register numbers
// ----------------------------------------------------------------
`define CEER_CAUSE_CRIT  6'h04
`define CEER_CAUSE_SCALL 6'h08
`define CEER_CAUSE_EXC   6'h10
`define CEER_FRAME_SHORT 4'h2
`define CEER_FRAME_LONG  4'h8
`define CEER_REG_R8      4'h8
`define CEER_REG_LR      4'he
`endif

//--- ceer_pkg.sv
`default_nettype none
package ceer_pkg;
  typedef enum logic [2:0] {
    CEER_M_APP, CEER_M_SUP, CEER_M_IRQ_LEVEL0, CEER_M_IRQ_LEVEL1,
    CEER_M_IRQ_LEVEL2, CEER_M_IRQ_LEVEL3, CEER_M_EXC, CEER_M_NMI
  } ceer_mode_t;
  typedef enum logic [1:0] {CEER_S_IDLE, CEER_S_PUSH, CEER_S_POP, CEER_S_DRAIN} ceer_state_t;
  typedef struct packed {
    logic [31:0]      pc;
    logic [4:0][31:0] r8_12;
    logic [31:0]      lr;
  } ceer_ctx_t;
  typedef struct packed {
    logic        vld;
    logic [3:0]  idx;
    logic [31:0] data;
  } ceer_regwr_t;
  typedef struct packed {
    logic        vld;
    logic [31:0] addr;
  } ceer_pcld_t;
endpackage : ceer_pkg
`default_nettype wire

//--- ceer_stack_mem.sv
`default_nettype none
module ceer_stack_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  // Read port, data one cycle after the request
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata
);
  logic [31:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_bad_aw
    $error("AW too narrow for DEPTH");
  end

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= 32'h0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : ceer_stack_mem
`default_nettype wire

//--- ceer_src_model.sv
`default_nettype none
module ceer_src_model (
  // Clock, reset, stimulus
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] raise,
  // Level request lines
  input  wire logic [3:0] ack,
  output logic      [3:0] req
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req <= 4'h0;
    end else begin
      req <= (req | raise) & ~ack;
    end
  end
endmodule : ceer_src_model
`default_nettype wire

//--- testbench.sv
`default_nettype none
`include "ceer_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ceer_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, insn_boundary = 1'b1, exc_req = 1'b0;
  logic dbg_req = 1'b0, dbg_exit = 1'b0, scall_req = 1'b0, rets_req = 1'b0, rete_req = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, status_reg, rdv, pa;
  logic [3:0] s_axi_wstrb = 4'hf, exc_code = 4'h0, crit_req = 4'h0, raise = 4'h0;
  logic [3:0] irq_level, irq_ack, crit_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic exc_ack, core_stall, dbg_mode, irq_out;
  ceer_pcld_t pc_load;
  ceer_regwr_t reg_restore, lst;
  ceer_mode_t reg_bank;
  ceer_ctx_t ctx = {32'h0000_2468, 128'h0, 32'h0000_1357, 32'h0};
  int errors = 0, checks_done = 0, cyc = 0, nrs;
  ceer_top #(.STACK_DEPTH(16)) ceer_top_i (.*);
  ceer_src_model ceer_src_model_i (.aclk(aclk), .aresetn(aresetn), .raise(raise), .ack(irq_ack), .req(irq_level));
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic wpc();
    nrs = 0;
    do begin
      @(posedge aclk);
      nrs += reg_restore.vld;
      if (reg_restore.vld) lst = reg_restore;
    end while (pc_load.vld !== 1'b1);
    pa = pc_load.addr;
  endtask : wpc
  task automatic rt(input logic [31:0] sr, input int n);
    rete_req <= 1'b1;
    do @(posedge aclk); while (core_stall !== 1'b1);
    rete_req <= 1'b0;
    wpc();
    repeat (2) @(posedge aclk);
    chk(pa === ctx.pc && status_reg === sr, "return");
    chk(nrs === n, "restored words");
  endtask : rt
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_crit();
    rd(8'h40);
    chk(rsp === 2'b10 && status_reg === `CEER_SR_RST, "reset or unmapped");
    raise <= 4'h4;
    insn_boundary <= 1'b0;
    crit_req <= 4'h1;
    repeat (8) @(posedge aclk);
    raise <= 4'h0;
    chk(irq_level === 4'h4 && crit_ack === 4'h0, "early accept");
    insn_boundary <= 1'b1;
    do @(posedge aclk); while (crit_ack[0] !== 1'b1);
    crit_req <= 4'h0;
    wpc();
    chk(pa === {`CEER_CAUSE_CRIT, 2'b00} && status_reg[24:22] === CEER_M_NMI, "crit entry");
    chk(status_reg[21] === 1'b1 && status_reg[16] === 1'b1, "crit masks");
    rd(`CEER_OFS_STK_LVL);
    chk(rdv === 32'h2, "short frame");
    rt(`CEER_SR_RST, 0);
    $display("test crit done");
  endtask : t_crit
  task automatic t_irq();
    wr(`CEER_OFS_HBASE, 32'h100);
    wr(`CEER_OFS_SR, 32'h0);
    wpc();
    chk(pa === 32'h108 && reg_bank === CEER_M_IRQ_LEVEL2, "irq entry");
    chk(status_reg[20:16] === 5'h0e, "level masks");
    rd(`CEER_OFS_STK_LVL);
    chk(rdv === 32'h8, "long frame");
    rt(32'h0, 6);
    chk(lst.idx === 4'h8 && lst.data === 32'h0000_1357, "last restored word");
    chk(irq_out === 1'b0, "irq out masked");
    wr(`CEER_OFS_EVT_MSK, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq_out === 1'b1, "irq out set");
    wr(`CEER_OFS_EVT_STS, 32'h1f);
    repeat (2) @(posedge aclk);
    chk(irq_out === 1'b0, "irq out cleared");
    dbg_req <= 1'b1;
    repeat (3) @(posedge aclk);
    dbg_req <= 1'b0;
    dbg_exit <= 1'b1;
    chk(dbg_mode === 1'b1, "debug entry");
    $display("test irq done");
  endtask : t_irq
  task automatic t_exc();
    exc_code <= 4'h3;
    exc_req <= 1'b1;
    do @(posedge aclk); while (exc_ack !== 1'b1);
    exc_req <= 1'b0;
    wpc();
    chk(pa === 32'h14c && reg_bank === CEER_M_EXC, "exception entry");
    chk(status_reg[21] === 1'b1 && status_reg[16] === 1'b1, "exception masks");
    scall_req <= 1'b1;
    do @(posedge aclk); while (core_stall !== 1'b1);
    scall_req <= 1'b0;
    wpc();
    chk(pa === 32'h120 && reg_bank === CEER_M_SUP, "scall entry");
    rets_req <= 1'b1;
    do @(posedge aclk); while (core_stall !== 1'b1);
    rets_req <= 1'b0;
    wpc();
    repeat (2) @(posedge aclk);
    chk(pa === ctx.pc && reg_bank === CEER_M_EXC, "scall return");
    rt(32'h0, 0);
    wr(8'h40, 32'h0);
    chk(rsp === 2'b10, "unmapped write");
    wr(`CEER_OFS_SR, 32'h0401_0000);
    dbg_req <= 1'b1;
    repeat (3) @(posedge aclk);
    dbg_req <= 1'b0;
    chk(dbg_mode === 1'b0, "debug masked");
    crit_req <= 4'h8;
    do @(posedge aclk); while (crit_ack[3] !== 1'b1);
    crit_req <= 4'h0;
    wpc();
    chk(pa === 32'h11c && reg_bank === CEER_M_EXC, "bus error entry");
    rt(32'h0401_0000, 0);
    $display("test exc done");
  endtask : t_exc
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_crit();
    t_irq();
    t_exc();
    test_done();
  end
endmodule : testbench
`default_nettype wire
